// *** core/iop_bank.sv ***
/*
 * 32-channel isolated output port bank: activation register and four
 * read-back output ports on the bridge's peripheral register port.
 * Assumes the bridge presents one access per strobe cycle, synchronous
 * to mclk, with a byte address and per-lane byte enables.
 */
`default_nettype none
module iop_bank #(
    parameter int NUM_PORTS = iop_pkg::NUM_PORTS,
    parameter int PORT_W = iop_pkg::PORT_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [iop_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_byte_en,
    input wire logic [iop_pkg::DATA_W-1:0] reg_wdata,
    output logic [iop_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output logic [NUM_PORTS*PORT_W-1:0] chan_on,
    output logic bank_active
);
    logic active_reg;
    logic active_next;
    logic [iop_pkg::DATA_W-1:0] rdata_reg;
    logic [iop_pkg::DATA_W-1:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic lane0_wr;
    logic act_hit;
    logic [NUM_PORTS-1:0] port_hit;
    logic [PORT_W-1:0] port_q [NUM_PORTS];

    // Only lane 0 carries data, so 8-bit and 32-bit accesses look alike
    assign lane0_wr = reg_wr && reg_byte_en[0];
    assign act_hit = (reg_addr == iop_pkg::ACTIVATION_CONTROL_OFFSET);

    always_comb begin
        port_hit = '0;
        unique case (reg_addr)
            iop_pkg::OUTPUT_PORT_0_OFFSET: port_hit[0] = 1'b1;
            iop_pkg::OUTPUT_PORT_1_OFFSET: port_hit[1] = 1'b1;
            iop_pkg::OUTPUT_PORT_2_OFFSET: port_hit[2] = 1'b1;
            iop_pkg::OUTPUT_PORT_3_OFFSET: port_hit[3] = 1'b1;
            default: port_hit = '0;
        endcase
    end

    always_comb begin
        active_next = active_reg;
        if (lane0_wr && act_hit) begin
            active_next = reg_wdata[iop_pkg::ACTIVE_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            active_reg <= iop_pkg::ACTIVE_RESET;
        end else begin
            active_reg <= active_next;
        end
    end

    // Ports held clear while inactive; writes before activation are lost
    for (genvar n = 0; n < NUM_PORTS; n++) begin : g_port
        iop_port_byte #(
            .WIDTH(PORT_W)
        ) u_port (
            .mclk(mclk),
            .rst_n(rst_n),
            .clear(!active_reg),
            .wr(lane0_wr && port_hit[n]),
            .din(reg_wdata[PORT_W-1:0]),
            .q(port_q[n])
        );
        assign chan_on[n*PORT_W +: PORT_W] = port_q[n];
    end

    always_comb begin
        rdata_next = iop_pkg::READ_UNMAPPED;
        rvalid_next = reg_rd;
        if (reg_rd) begin
            // Activation is write-only and reads as zero
            for (int i = 0; i < NUM_PORTS; i++) begin
                if (port_hit[i]) begin
                    rdata_next = {{(iop_pkg::DATA_W-PORT_W){1'b0}}, port_q[i]};
                end
            end
            if (!reg_byte_en[0]) begin
                rdata_next = iop_pkg::READ_UNMAPPED;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_reg <= iop_pkg::READ_UNMAPPED;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign bank_active = active_reg;

    sequence s_act_write(logic v);
        reg_wr && reg_byte_en[0] && act_hit && reg_wdata[0] == v;
    endsequence

    sequence s_port0_write;
        reg_wr && reg_byte_en[0] && port_hit[0];
    endsequence

    property p_reset_inactive;
        @(posedge mclk) !rst_n |=> !bank_active && chan_on == '0;
    endproperty
    a_reset_inactive: assert property (p_reset_inactive)
        else $error("bank not inactive after reset");

    property p_activate;
        @(posedge mclk) disable iff (!rst_n) s_act_write(1'b1) |=> bank_active;
    endproperty
    a_activate: assert property (p_activate)
        else $error("activation write did not activate");

    property p_stay_inactive;
        @(posedge mclk) disable iff (!rst_n)
            !bank_active && !(reg_wr && reg_byte_en[0] && act_hit && reg_wdata[0])
            |=> !bank_active;
    endproperty
    a_stay_inactive: assert property (p_stay_inactive)
        else $error("bank activated without bit 0 write");

    property p_deactivate;
        @(posedge mclk) disable iff (!rst_n) s_act_write(1'b0) |=> ##1 chan_on == '0;
    endproperty
    a_deactivate: assert property (p_deactivate)
        else $error("outputs not cleared after deactivation");

    property p_port_map;
        @(posedge mclk) disable iff (!rst_n)
            (s_port0_write and (bank_active && !act_hit))
            |=> chan_on[7:0] == $past(reg_wdata[7:0]);
    endproperty
    a_port_map: assert property (p_port_map)
        else $error("port 0 write not on channels 0 to 7");

    property p_readback;
        @(posedge mclk) disable iff (!rst_n)
            reg_rd && reg_byte_en[0] && port_hit[3]
            |=> reg_rvalid && reg_rdata == {24'h000000, $past(chan_on[31:24])};
    endproperty
    a_readback: assert property (p_readback)
        else $error("port 3 read-back mismatch");

    property p_act_reads_zero;
        @(posedge mclk) disable iff (!rst_n) reg_rd && act_hit |=> reg_rdata == 32'h00000000;
    endproperty
    a_act_reads_zero: assert property (p_act_reads_zero)
        else $error("activation register readable");

    property p_off_inactive;
        @(posedge mclk) disable iff (!rst_n) !bank_active [*2] |-> chan_on == '0;
    endproperty
    a_off_inactive: assert property (p_off_inactive)
        else $error("output on while inactive");

    // Steps: activate, one cycle with no activation write, then a port 0 write
    sequence s_act_then_port0;
        s_act_write(1'b1) ##1 !(reg_wr && act_hit) ##1 s_port0_write;
    endsequence

    property p_first_port_write;
        @(posedge mclk) disable iff (!rst_n)
            s_act_then_port0 |=> chan_on[7:0] == $past(reg_wdata[7:0]);
    endproperty
    a_first_port_write: assert property (p_first_port_write)
        else $error("port write after activation lost");

    property p_inactive_write_lost;
        @(posedge mclk) disable iff (!rst_n)
            (s_port0_write and !bank_active) |=> chan_on[7:0] == 8'h00;
    endproperty
    a_inactive_write_lost: assert property (p_inactive_write_lost)
        else $error("port write landed while inactive");

    property p_read_answer;
        @(posedge mclk) disable iff (!rst_n) reg_rd |=> reg_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read strobe not answered");

    property p_idle_bus_quiet;
        @(posedge mclk) disable iff (!rst_n)
            !reg_rd |=> !reg_rvalid && reg_rdata == 32'h00000000;
    endproperty
    a_idle_bus_quiet: assert property (p_idle_bus_quiet)
        else $error("read answer without read strobe");

    property p_upper_bytes_zero;
        @(posedge mclk) disable iff (!rst_n) reg_rdata[31:8] == 24'h000000;
    endproperty
    a_upper_bytes_zero: assert property (p_upper_bytes_zero)
        else $error("read data above bit 7 not zero");

    property p_lane_off_ignored;
        @(posedge mclk) disable iff (!rst_n)
            reg_wr && !reg_byte_en[0] && bank_active |=> $stable(chan_on);
    endproperty
    a_lane_off_ignored: assert property (p_lane_off_ignored)
        else $error("write without lane 0 changed outputs");

    property p_port_hold;
        @(posedge mclk) disable iff (!rst_n)
            bank_active && !reg_wr |=> $stable(chan_on);
    endproperty
    a_port_hold: assert property (p_port_hold)
        else $error("outputs changed without a write");
endmodule
`default_nettype wire

// *** core/iop_pkg.sv ***
/*
 * Shared constants of the isolated output port bank: register offsets,
 * field positions, reset values and widths.
 * Assumes a byte address from the bridge's peripheral bus, one 32-bit
 * slot per register, meaningful data in byte lane 0 only.
 */
`default_nettype none
package iop_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PORT_W = 8;
    localparam int NUM_PORTS = 4;
    localparam int CHAN_W = NUM_PORTS * PORT_W;
    localparam logic [ADDR_W-1:0] ACTIVATION_CONTROL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] OUTPUT_PORT_0_OFFSET = 8'hC0;
    localparam logic [ADDR_W-1:0] OUTPUT_PORT_1_OFFSET = 8'hC4;
    localparam logic [ADDR_W-1:0] OUTPUT_PORT_2_OFFSET = 8'hC8;
    localparam logic [ADDR_W-1:0] OUTPUT_PORT_3_OFFSET = 8'hCC;
    localparam int ACTIVE_BIT = 0;
    localparam logic ACTIVE_RESET = 1'b0;
    localparam logic [PORT_W-1:0] PORT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h0000_0000;
endpackage
`default_nettype wire

// *** core/iop_port_byte.sv ***
/*
 * One byte-wide output port register with write and forced clear.
 * Assumes a single clock and synchronous active-low reset.
 */
`default_nettype none
module iop_port_byte #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic wr,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    always_comb begin
        q_next = q_reg;
        // Clear wins: an inactive bank must never latch a value
        if (clear) begin
            q_next = '0;
        end else if (wr) begin
            q_next = din;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule
`default_nettype wire

// *** sim/iop_bank_tb.sv ***
/*
 * Self-checking bench for iop_bank: calls of the host model plus compares.
 * Assumes iop_pkg and iop_host_model are compiled first.
 */
`default_nettype none
module iop_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk;
    logic rst_n;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [3:0] reg_byte_en;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic [31:0] chan_on;
    logic bank_active;
    logic [31:0] exp_chan;
    logic [7:0] pv;
    int err_count = 0;
    int n_compared = 0;
    iop_bank u_iop_bank (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_byte_en(reg_byte_en), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chan_on(chan_on),
        .bank_active(bank_active));
    iop_host_model u_iop_host_model (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_byte_en(reg_byte_en), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        logic ok;
        u_iop_host_model.access(1'b0, a, be, d, q, ok);
    endtask
    task automatic rd(input logic [7:0] a, input logic [3:0] be, input logic [31:0] exp);
        logic [31:0] q;
        logic ok;
        u_iop_host_model.access(1'b1, a, be, 32'h0000_0000, q, ok);
        chk("rvalid", 32'h0000_0001, {31'h0, ok});
        chk("rdata", exp, q);
    endtask
    initial begin
        rst_n = 1'b0;
        exp_chan = 32'h0000_0000;
        repeat (3) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        chk("bank_active", 32'h0, {31'h0, bank_active});
        chk("chan_on", 32'h0, chan_on);
        wr(8'hC0, 32'h0000_00FF, 4'h1);
        chk("chan_on", 32'h0, chan_on);
        rd(8'hC0, 4'h1, 32'h0);
        rd(8'h00, 4'h1, 32'h0);
        wr(8'h00, 32'h0000_0001, 4'h1);
        chk("bank_active", 32'h1, {31'h0, bank_active});
        // Distinct byte per port exposes any lane swap
        for (int n = 0; n < 4; n++) begin
            pv = 8'h5A + 8'(n * 8'h31);
            exp_chan[8*n+:8] = pv;
            wr(8'hC0 + 8'(4 * n), {24'hFFFFFF, pv}, 4'hF);
            chk("chan_on", exp_chan, chan_on);
        end
        for (int n = 0; n < 4; n++) begin
            rd(8'hC0 + 8'(4 * n), 4'h1, {24'h0, exp_chan[8*n+:8]});
        end
        rd(8'hC4, 4'h0, 32'h0);
        rd(8'hD0, 4'h1, 32'h0);
        wr(8'hC4, 32'h0000_0000, 4'h0);
        chk("chan_on", exp_chan, chan_on);
        wr(8'h00, 32'h0000_0002, 4'h1);
        @(posedge mclk);
        #1;
        chk("bank_active", 32'h0, {31'h0, bank_active});
        chk("chan_on", 32'h0, chan_on);
        wr(8'h00, 32'h0000_0001, 4'h1);
        wr(8'hC8, 32'h0000_00C3, 4'h1);
        chk("chan_on", 32'h00C3_0000, chan_on);
        // Mid-run reset must drop the bank back to inactive
        rst_n = 1'b0;
        @(posedge mclk);
        #1;
        rst_n = 1'b1;
        chk("bank_active", 32'h0, {31'h0, bank_active});
        chk("chan_on", 32'h0, chan_on);
        summarize();
    end
endmodule
`default_nettype wire

// *** sim/iop_host_model.sv ***
/*
 * Host-side bridge model: one register access per call, strobe held one cycle.
 * Assumes iop_bank register port on the same mclk, driven 1 ns after the edge.
 */
`default_nettype none
module iop_host_model (
    input wire logic mclk,
    output logic [iop_pkg::ADDR_W-1:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [3:0] reg_byte_en,
    output logic [iop_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [iop_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_byte_en = 4'h0;
        reg_wdata = 32'h0000_0000;
    end
    // Callers may send port traffic before activating the bank; the bench writes and reads C0 first
    task automatic access(input logic is_rd, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d, output logic [31:0] q, output logic ok);
        int i;
        reg_addr = a;
        reg_byte_en = be;
        reg_wdata = d;
        reg_wr = !is_rd;
        reg_rd = is_rd;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // Released address and data lines show inverted junk, not the last value
        reg_addr = ~a;
        reg_wdata = ~d;
        ok = !is_rd;
        q = 32'h0000_0000;
        // Answer stands one cycle from the taking edge, so look before waiting
        for (i = 0; i < 4 && is_rd && !ok; i++) begin
            if (reg_rvalid === 1'b1) begin
                ok = 1'b1;
                q = reg_rdata;
            end else begin
                @(posedge mclk);
                #1;
            end
        end
        @(posedge mclk);
        #1;
    endtask
endmodule
`default_nettype wire
